// *** hw/solm_clamp.sv ***
// Registered symmetric saturation of a signed word to a programmable magnitude
`default_nettype none
module solm_clamp #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic signed [W:0] value_i,
  input wire logic [W-2:0] limit_i,
  output logic signed [W-1:0] value_o
);
  logic signed [W:0] pos_lim;
  logic signed [W:0] neg_lim;

  assign pos_lim = $signed({2'b00, limit_i});
  assign neg_lim = -pos_lim;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= '0;
    end else if (value_i > pos_lim) begin
      value_o <= pos_lim[W-1:0];
    end else if (value_i < neg_lim) begin
      value_o <= neg_lim[W-1:0];
    end else begin
      value_o <= value_i[W-1:0];
    end
  end
endmodule
`default_nettype wire

// *** hw/solm_top.sv ***
// Servo output conditioning, foldback, settle and tracking monitor with Avalon-MM registers
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`default_nettype none
module solm_top #(
  parameter logic [39:0] ENERGY_FULL = 40'h00_0100_0000,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Servo datapath
  input wire logic signed [DW-1:0] filter_out_i,
  input wire logic signed [DW-1:0] current_cmd_i,
  input wire logic signed [31:0] demand_pos_i,
  input wire logic signed [31:0] encoder_pos_i,
  input wire logic profile_done_i,
  output logic signed [DW-1:0] drive_o,
  output logic signed [DW-1:0] current_o,
  output logic servo_tick_o,
  output logic move_done_o,
  output logic settled_o,
  output logic tracking_o,
  output logic foldback_o,
  output logic axis_stop_o
);
  import solm_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic loop_en;
  logic [6:0] cur_cap_pct;
  logic [6:0] energy_cap_pct;
  logic [15:0] drive_offset;
  logic [14:0] drive_limit;
  logic [15:0] settle_band;
  logic [14:0] settle_time;
  logic [15:0] track_win;
  logic [15:0] err_limit;
  logic motion_err;
  logic [31:0] pos_err;
  logic [31:0] energy;
  logic [14:0] hold_cnt;
  logic [TICK_W-1:0] div_cnt;
  logic tick;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic [31:0] wr_word;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // One wait cycle per access: read data are registered while waitrequest is
  // high, so the master samples them at the same edge it sees waitrequest low.
  assign bus_wr = avs_write_i && !avs_waitrequest_o;
  assign bus_rd = avs_read_i && avs_waitrequest_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[ST_MOVE_DONE] = move_done_o;
    status_word[ST_TRACKING] = tracking_o;
    status_word[ST_SETTLED] = settled_o;
    status_word[ST_MOTION_ERR] = motion_err;
    status_word[ST_FOLDBACK] = foldback_o;
  end

  always_comb begin
    case (avs_address_i)
      OFS_CTRL: next_rdata = {31'h0000_0000, loop_en};
      OFS_CUR_CAP: next_rdata = {25'h000_0000, cur_cap_pct};
      OFS_ENERGY_CAP: next_rdata = {25'h000_0000, energy_cap_pct};
      OFS_DRIVE_OFFSET: next_rdata = {{16{drive_offset[15]}}, drive_offset};
      OFS_DRIVE_LIMIT: next_rdata = {17'h0_0000, drive_limit};
      OFS_SETTLE_BAND: next_rdata = {16'h0000, settle_band};
      OFS_SETTLE_TIME: next_rdata = {17'h0_0000, settle_time};
      OFS_TRACK_WIN: next_rdata = {16'h0000, track_win};
      OFS_ERR_LIMIT: next_rdata = {16'h0000, err_limit};
      OFS_STATUS: next_rdata = status_word;
      OFS_POS_ERR: next_rdata = pos_err;
      OFS_ENERGY: next_rdata = energy;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // ****************************************************************
  // Configuration writes
  // ****************************************************************
  // Old contents come from the read mux so masked byte lanes keep their value
  assign wr_word = merge(next_rdata, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_en <= 1'b0;
      cur_cap_pct <= RST_CUR_CAP;
      energy_cap_pct <= RST_ENERGY_CAP;
      drive_offset <= RST_DRIVE_OFFSET;
      drive_limit <= RST_DRIVE_LIMIT;
      settle_band <= RST_SETTLE_BAND;
      settle_time <= RST_SETTLE_TIME;
      track_win <= RST_TRACK_WIN;
      err_limit <= RST_ERR_LIMIT;
    end else if (bus_wr) begin
      case (avs_address_i)
        OFS_CTRL: begin
          loop_en <= wr_word[CTRL_LOOP_EN];
        end
        OFS_CUR_CAP: begin
          // Percent above full scale saturates; the peak itself is fixed
          cur_cap_pct <= (wr_word > 32'(PCT_FULL)) ? PCT_FULL : wr_word[6:0];
        end
        OFS_ENERGY_CAP: begin
          energy_cap_pct <= (wr_word > 32'(PCT_FULL)) ? PCT_FULL : wr_word[6:0];
        end
        OFS_DRIVE_OFFSET: begin
          drive_offset <= wr_word[15:0];
        end
        OFS_DRIVE_LIMIT: begin
          drive_limit <= wr_word[14:0];
        end
        OFS_SETTLE_BAND: begin
          settle_band <= wr_word[15:0];
        end
        OFS_SETTLE_TIME: begin
          settle_time <= wr_word[14:0];
        end
        OFS_TRACK_WIN: begin
          track_win <= wr_word[15:0];
        end
        OFS_ERR_LIMIT: begin
          err_limit <= wr_word[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Servo cycle divider
  // ****************************************************************
  assign tick = (div_cnt == TICK_W'(SERVO_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= '0;
      servo_tick_o <= 1'b0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
      servo_tick_o <= tick;
    end
  end

  // ****************************************************************
  // Position error
  // ****************************************************************
  logic signed [32:0] err_diff;
  logic [32:0] err_abs;

  assign err_diff = {demand_pos_i[31], demand_pos_i} - {encoder_pos_i[31], encoder_pos_i};
  assign err_abs = err_diff[32] ? 33'(-err_diff) : 33'(err_diff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_err <= 32'h0000_0000;
    end else if (tick) begin
      // Saturate so a huge error never wraps back into a window
      pos_err <= err_abs[32] ? 32'hFFFF_FFFF : err_abs[31:0];
    end
  end

  // ****************************************************************
  // Settle monitor
  // ****************************************************************
  logic settle_cond;

  assign settle_cond = profile_done_i && (pos_err <= {16'h0000, settle_band});

  // Settled is written only here, never from the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt <= '0;
      settled_o <= 1'b0;
    end else if (settle_time == '0) begin
      hold_cnt <= '0;
      settled_o <= profile_done_i;
    end else if (!settle_cond) begin
      hold_cnt <= '0;
      settled_o <= 1'b0;
    end else if (tick) begin
      if (hold_cnt >= settle_time) begin
        settled_o <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

  // Never completes while the band is unreached and the count is nonzero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      move_done_o <= 1'b0;
    end else begin
      move_done_o <= profile_done_i && settled_o;
    end
  end

  // ****************************************************************
  // Tracking window and motion error
  // ****************************************************************
  // Tracking only reports; it feeds nothing that stops the axis
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tracking_o <= 1'b1;
    end else if (pos_err > {16'h0000, track_win}) begin
      tracking_o <= 1'b0;
    end else begin
      tracking_o <= 1'b1;
    end
  end

  // Sticky; software clears by writing one to its status bit, a new trip wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motion_err <= 1'b0;
      axis_stop_o <= 1'b0;
    end else begin
      if (loop_en && pos_err > {16'h0000, err_limit}) begin
        motion_err <= 1'b1;
      end else if (bus_wr && avs_address_i == OFS_STATUS && avs_byteenable_i[1]
                   && avs_writedata_i[ST_MOTION_ERR]) begin
        motion_err <= 1'b0;
      end
      axis_stop_o <= motion_err;
    end
  end

  // ****************************************************************
  // Current foldback
  // ****************************************************************
  logic [15:0] cur_cap;
  logic [31:0] energy_cap;
  logic [15:0] cur_abs;
  logic [32:0] next_energy;
  logic [22:0] cap_prod;
  logic [46:0] ecap_prod;

  assign cap_prod = PEAK_FULL * cur_cap_pct;
  assign cur_cap = 16'(cap_prod / PCT_FULL);
  assign ecap_prod = ENERGY_FULL * energy_cap_pct;
  assign energy_cap = 32'(ecap_prod / PCT_FULL);
  assign cur_abs = current_cmd_i[15] ? 16'(-current_cmd_i) : 16'(current_cmd_i);

  always_comb begin
    if (cur_abs > cur_cap) begin
      next_energy = {1'b0, energy} + {17'h0_0000, 16'(cur_abs - cur_cap)};
    end else if ({16'h0000, 16'(cur_cap - cur_abs)} >= energy) begin
      next_energy = '0;
    end else begin
      next_energy = {1'b0, energy} - {17'h0_0000, 16'(cur_cap - cur_abs)};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      energy <= 32'h0000_0000;
    end else if (tick) begin
      energy <= next_energy[32] ? 32'hFFFF_FFFF : next_energy[31:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      foldback_o <= 1'b0;
    end else if (energy > energy_cap) begin
      foldback_o <= 1'b1;
    end else if (energy == 32'h0000_0000) begin
      foldback_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Output conditioning
  // ****************************************************************
  logic signed [DW:0] drive_sum;
  logic [DW-2:0] cur_lim;

  // Offset only while the loop is closed
  assign drive_sum = {filter_out_i[DW-1], filter_out_i}
                     + (loop_en ? {drive_offset[15], drive_offset} : 17'h0_0000);
  assign cur_lim = foldback_o ? cur_cap[DW-2:0] : PEAK_FULL[DW-2:0];

  solm_clamp #(.W(DW)) u_drive_clamp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .value_i(drive_sum),
    .limit_i(drive_limit),
    .value_o(drive_o)
  );

  solm_clamp #(.W(DW)) u_cur_clamp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .value_i({current_cmd_i[DW-1], current_cmd_i}),
    .limit_i(cur_lim),
    .value_o(current_o)
  );
endmodule
`default_nettype wire

// *** include/solm_pkg.sv ***
// Constants shared by the servo output limit and settle monitor
`default_nettype none
package solm_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ = 20000;
  localparam int SERVO_PERIOD_NS = 102400;
  localparam int SERVO_CYCLES = (SERVO_PERIOD_NS * CLK_KHZ + 999_999) / 1_000_000;
  localparam int TICK_W = $clog2(SERVO_CYCLES);

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CUR_CAP = 8'h04;
  localparam logic [7:0] OFS_ENERGY_CAP = 8'h08;
  localparam logic [7:0] OFS_DRIVE_OFFSET = 8'h0C;
  localparam logic [7:0] OFS_DRIVE_LIMIT = 8'h10;
  localparam logic [7:0] OFS_SETTLE_BAND = 8'h14;
  localparam logic [7:0] OFS_SETTLE_TIME = 8'h18;
  localparam logic [7:0] OFS_TRACK_WIN = 8'h1C;
  localparam logic [7:0] OFS_ERR_LIMIT = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_POS_ERR = 8'h28;
  localparam logic [7:0] OFS_ENERGY = 8'h2C;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int CTRL_LOOP_EN = 0;
  localparam int ST_MOVE_DONE = 0;
  localparam int ST_TRACKING = 13;
  localparam int ST_SETTLED = 14;
  localparam int ST_MOTION_ERR = 15;
  localparam int ST_FOLDBACK = 25;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [15:0] PEAK_FULL = 16'h7FFF;
  localparam logic [6:0] RST_CUR_CAP = 7'h64;
  localparam logic [6:0] RST_ENERGY_CAP = 7'h64;
  localparam logic [15:0] RST_DRIVE_OFFSET = 16'h0000;
  localparam logic [14:0] RST_DRIVE_LIMIT = 15'h7FFF;
  localparam logic [15:0] RST_SETTLE_BAND = 16'h0014;
  localparam logic [14:0] RST_SETTLE_TIME = 15'h0000;
  localparam logic [15:0] RST_TRACK_WIN = 16'h0064;
  localparam logic [15:0] RST_ERR_LIMIT = 16'hFFFF;
endpackage
`default_nettype wire

// *** verification/solm_stage_model.sv ***
// Behavioural motor stage: encoder trails the demand by a commanded lag
`default_nettype none
module solm_stage_model (
  input wire logic clk_i,
  input wire logic signed [31:0] demand_i,
  input wire logic signed [31:0] lag_i,
  output logic signed [31:0] encoder_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered so the encoder never answers in the same cycle as the demand
  always_ff @(posedge clk_i) begin
    encoder_o <= demand_i - lag_i;
  end
endmodule
`default_nettype wire

// *** verification/solm_top_monitor.sv ***
// Concurrent checks on the ports of the servo limit and settle monitor
`default_nettype none
module solm_top_monitor
  import solm_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic signed [DW-1:0] current_cmd_i,
  input wire logic profile_done_i,
  input wire logic signed [DW-1:0] current_o,
  input wire logic servo_tick_o,
  input wire logic move_done_o,
  input wire logic settled_o,
  input wire logic tracking_o,
  input wire logic foldback_o,
  input wire logic axis_stop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap;
  logic seen;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************************************
  // Servo cycle spacing
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap <= 0;
      seen <= 1'b0;
    end else if (servo_tick_o) begin
      gap <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_tick_spacing: assert property (servo_tick_o && seen |-> gap == SERVO_CYCLES - 1)
    else $error("servo tick spacing wrong");
  a_move_done_pair: assert property (move_done_o == $past(profile_done_i && settled_o))
    else $error("move done not profile done and settled");
  a_settle_at_rest: assert property ($rose(settled_o) |-> $past(profile_done_i))
    else $error("settled rose during a move");
  a_settle_lapse: assert property ($fell(profile_done_i) |=> !settled_o)
    else $error("settled kept after move start");
  // Window writes may legally move the flag off the servo cycle
  a_track_on_tick: assert property ($changed(tracking_o) && !$past(avs_write_i)
    && !$past(avs_write_i, 2) |-> $past(servo_tick_o) || $past(servo_tick_o, 2)
    || $past(servo_tick_o, 3)) else $error("tracking changed off servo cycle");
  a_current_pass: assert property (!foldback_o && !$past(foldback_o) &&
    !$past(foldback_o, 2) && !$past(rst_i) |-> current_o ==
    (($past(current_cmd_i) == 16'sh8000) ? 16'sh8001 : $past(current_cmd_i)))
    else $error("current changed without foldback");
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer longer than one cycle");
  c_settled: cover property ($rose(settled_o));
  c_foldback: cover property ($rose(foldback_o));
  c_track_lost: cover property ($fell(tracking_o));
  c_stop: cover property ($rose(axis_stop_o));
endmodule
`default_nettype wire

// *** verification/solm_top_tb.sv ***
// Self-checking bench for the servo output limit and settle monitor
`default_nettype none
module solm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import solm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq;
  logic [31:0] rres;
  logic signed [15:0] filt = 16'h0000;
  logic signed [15:0] cmd = 16'h0000;
  logic signed [31:0] dem = 32'h0001_2345;
  logic signed [31:0] lag = 32'h0000_0000;
  logic signed [31:0] enc;
  logic pdone = 1'b0;
  logic signed [15:0] drv;
  logic signed [15:0] cur;
  logic tick, mdone, settled, track, fold, stop;
  logic [31:0] seed = 32'haec7;
  logic [31:0] rv;
  logic [31:0] rw;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30};
  logic [31:0] rx [10] = '{0, 32'h64, 32'h64, 0, 32'h7FFF, 32'h14, 0, 32'h64, 32'hFFFF, 0};
  solm_stage_model solm_stage_model_inst (.clk_i(clk_i), .demand_i(dem), .lag_i(lag),
    .encoder_o(enc));
  solm_top #(.ENERGY_FULL(40'h00_0000_1000)) solm_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .filter_out_i(filt), .current_cmd_i(cmd), .demand_pos_i(dem), .encoder_pos_i(enc),
    .profile_done_i(pdone), .drive_o(drv), .current_o(cur), .servo_tick_o(tick),
    .move_done_o(mdone), .settled_o(settled), .tracking_o(track), .foldback_o(fold),
    .axis_stop_o(stop));
  always #25 clk_i = ~clk_i;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] exp_drv(logic signed [15:0] f, logic signed [15:0] o,
    logic [14:0] l, logic e);
    int s;
    s = int'(f) + (e ? int'(o) : 0);
    if (s > int'(l)) s = int'(l);
    if (s < -int'(l)) s = -int'(l);
    return {16'h0000, s[15:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    rres = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      while (tick !== 1'b1) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // About twenty servo cycles of tests, so this leaves ample margin
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, ra[i], 0);
      chk("reset value", rx[i], rres);
    end
    bus(1'b1, OFS_CUR_CAP, 32'h0000_00C8);
    bus(1'b0, OFS_CUR_CAP, 0);
    chk("current cap saturates", 32'h0000_0064, rres);
    for (int i = 0; i < 12; i++) begin
      rv = xs();
      rw = xs();
      if (i == 0) rv = 32'hFFFF_8000;
      if (i == 0) rw = 32'h0000_8000;
      if (i == 1) rv[30:16] = 15'h0000;
      bus(1'b1, OFS_CTRL, {31'h0, i[0]});
      bus(1'b1, OFS_DRIVE_OFFSET, {16'h0000, rv[15:0]});
      bus(1'b1, OFS_DRIVE_LIMIT, {17'h0, rv[30:16]});
      filt <= rw[15:0];
      repeat (3) @(posedge clk_i);
      chk("drive", exp_drv(rw[15:0], rv[15:0], rv[30:16], i[0]), {16'h0000, drv});
    end
    bus(1'b1, OFS_CTRL, 1);
    lag <= 1000;
    pdone <= 1'b1;
    ticks(1);
    chk("settled time zero", 1, settled);
    chk("move done", 1, mdone);
    chk("tracking out", 0, track);
    chk("no stop", 0, stop);
    bus(1'b1, OFS_STATUS, 0);
    bus(1'b0, OFS_STATUS, 0);
    chk("settled bit", 1, rres[ST_SETTLED]);
    bus(1'b0, OFS_POS_ERR, 0);
    chk("position error", 1000, rres);
    lag <= -10;
    ticks(1);
    chk("tracking back", 1, track);
    bus(1'b1, OFS_SETTLE_TIME, 2);
    pdone <= 1'b0;
    lag <= 1000;
    ticks(1);
    chk("settled in move", 0, settled);
    pdone <= 1'b1;
    ticks(4);
    chk("outside band", 0, settled);
    lag <= 5;
    ticks(2);
    chk("hold early", 0, settled);
    bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    @(posedge clk_i);
    chk("settled not writable", 0, settled);
    ticks(3);
    chk("hold done", 1, settled);
    chk("move done held", 1, mdone);
    lag <= 1000;
    ticks(1);
    chk("settle lapse", 0, settled);
    bus(1'b1, OFS_ERR_LIMIT, 50);
    ticks(1);
    chk("axis stop", 1, stop);
    bus(1'b0, OFS_STATUS, 0);
    chk("motion bit", 1, rres[ST_MOTION_ERR]);
    lag <= 0;
    bus(1'b1, OFS_ERR_LIMIT, 32'hFFFF);
    bus(1'b1, OFS_STATUS, 32'h0000_8000);
    bus(1'b0, OFS_STATUS, 0);
    chk("motion cleared", 0, rres[ST_MOTION_ERR]);
    bus(1'b1, OFS_CUR_CAP, 10);
    cmd <= 16'sd5000;
    ticks(1);
    bus(1'b0, OFS_ENERGY, 0);
    chk("energy", 5000 - 32767 * 10 / 100, rres);
    chk("current free", 5000, {16'h0000, cur});
    ticks(2);
    chk("foldback", 1, fold);
    chk("current capped", 32767 * 10 / 100, {16'h0000, cur});
    bus(1'b0, OFS_STATUS, 0);
    chk("foldback bit", 1, rres[ST_FOLDBACK]);
    cmd <= 16'sd100;
    ticks(2);
    chk("foldback cleared", 0, fold);
    chk("current restored", 100, {16'h0000, cur});
    end_sim();
  end
endmodule
bind solm_top solm_top_monitor #(.DW(DW)) solm_top_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .current_cmd_i(current_cmd_i), .profile_done_i(profile_done_i), .current_o(current_o),
  .servo_tick_o(servo_tick_o), .move_done_o(move_done_o), .settled_o(settled_o),
  .tracking_o(tracking_o), .foldback_o(foldback_o), .axis_stop_o(axis_stop_o));
`default_nettype wire
